// *** bsfpb_flags_portb.sv ***
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Port B transfers happen only at a rising edge of the Port B clock.
// - Transfer enable low allows a Port B transfer; high blocks any transfer.
// - In read direction, output enable low drives the bus, high floats it.
// - A-to-B empty flag low means no data; Port B reads are ignored.
// - Bypass: A-to-B empty high means a message waits; low after Port B reads.
// - Almost-empty low while count at or below offset, high above it.
// - All four offsets reset to eight words.
// - Almost-full low above depth minus offset, high at or below it.
// - Full flags follow the writer's clock, empty flags the reader's.
// - A-to-B full flag low means full; Port A writes are ignored.
// - Bypass: A-to-B full low while the message waits for Port B.
// - B-to-A empty flag low means no data; Port A reads are ignored.
// - Bypass: B-to-A empty high means message waits; low cycle after Port A reads.
// - B-to-A full flag low means full; Port B writes are ignored.
// - Bypass: B-to-A full low while the message waits for Port A.
// - Bypass indicator is low in bypass mode, high in normal mode, on Port B clock.
// - Reset low reinitialises queues, flags, offsets and mode.
// - Bypass Port B write fills B-to-A message; read returns A-to-B message.
module bsfpb_flags_portb (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        master_reset_n,
    input  wire logic        port_b_clock,
    input  wire logic        port_b_transfer_enable_n,
    input  wire logic        port_b_direction,
    input  wire logic        port_b_output_enable_n,
    input  wire logic [17:0] port_b_data_in,
    output logic      [17:0] port_b_data_out,
    output logic             port_b_data_oe,
    output logic             a_to_b_empty_n,
    output logic             a_to_b_almost_empty_n,
    output logic             a_to_b_almost_full_n,
    output logic             a_to_b_full_n,
    output logic             b_to_a_empty_n,
    output logic             b_to_a_almost_empty_n,
    output logic             b_to_a_almost_full_n,
    output logic             b_to_a_full_n,
    output logic             port_b_bypass_indicator_n
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [8:0] next_count(input logic [8:0] cnt, input logic up,
                                              input logic down);
        next_count = cnt + 9'(up) - 9'(down);
    endfunction

    function automatic logic almost_empty_n(input logic [8:0] cnt, input logic [8:0] off);
        almost_empty_n = (cnt > off);
    endfunction

    function automatic logic almost_full_n(input logic [8:0] cnt, input logic [8:0] off);
        almost_full_n = ({1'b0, cnt} + {1'b0, off}) <= {1'b0, bsfpb_pkg::DEPTH_COUNT};
    endfunction

    // ****************************************************************
    // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
    // ****************************************************************
    localparam int SW = 23;
    // Transfer enable and output enable settle at their idle high level after reset
    localparam logic [SW-1:0] SYNC_IDLE = 23'h0_000a;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] pin_stable;
    logic [SW-1:0] next_pin_stable;

    assign pin_raw = {port_b_data_in, master_reset_n, port_b_output_enable_n,
                      port_b_direction, port_b_transfer_enable_n, port_b_clock};
    assign next_pin_stable = (sync2 & sync3) | (pin_stable & (sync2 | sync3));

    // Synchroniser chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1      <= SYNC_IDLE;
            sync2      <= SYNC_IDLE;
            sync3      <= SYNC_IDLE;
            pin_stable <= SYNC_IDLE;
        end else begin
            sync1      <= pin_raw;
            sync2      <= sync1;
            sync3      <= sync2;
            pin_stable <= next_pin_stable;
        end
    end

    // Qualified pin levels
    wire        b_edge   = next_pin_stable[0] & ~pin_stable[0];
    wire        b_en     = ~pin_stable[1];
    wire        b_dir_rd = (pin_stable[2] == bsfpb_pkg::DIR_READ);
    wire        b_oe_n   = pin_stable[3];
    wire        clear    = ~pin_stable[4];
    wire [17:0] b_data   = pin_stable[22:5];

    // ****************************************************************
    // Mode, offsets, bypass message registers
    // ****************************************************************
    bsfpb_pkg::bsfpb_mode_t mode;
    logic [8:0]  off_ae_ab;
    logic [8:0]  off_af_ab;
    logic [8:0]  off_ae_ba;
    logic [8:0]  off_af_ba;
    logic [17:0] ab_msg;
    logic [17:0] ba_msg;
    logic        ab_msg_valid;
    logic        ba_msg_valid;
    logic [17:0] ab_head;
    logic [17:0] ba_head;
    logic [8:0]  ab_count;
    logic [8:0]  ba_count;

    wire bypass = (mode == bsfpb_pkg::MODE_BYPASS);

    // APB decode
    wire apb_go   = psel & penable;
    wire sel_ctrl = (paddr == bsfpb_pkg::ADDR_CTRL);
    wire sel_stat = (paddr == bsfpb_pkg::ADDR_STATUS);
    wire sel_data = (paddr == bsfpb_pkg::ADDR_DATA);
    wire sel_aeab = (paddr == bsfpb_pkg::ADDR_AE_AB);
    wire sel_afab = (paddr == bsfpb_pkg::ADDR_AF_AB);
    wire sel_aeba = (paddr == bsfpb_pkg::ADDR_AE_BA);
    wire sel_afba = (paddr == bsfpb_pkg::ADDR_AF_BA);
    wire mapped   = sel_ctrl | sel_stat | sel_data | sel_aeab | sel_afab | sel_aeba
                  | sel_afba;
    wire wr_go    = apb_go & pwrite & mapped;
    wire a_wr     = wr_go & sel_data;
    wire a_rd     = apb_go & ~pwrite & sel_data;

    // Transfer requests and acceptance
    wire b_rd_req = b_edge & b_en & b_dir_rd;
    wire b_wr_req = b_edge & b_en & ~b_dir_rd;
    wire ab_push  = ~bypass & a_wr & a_to_b_full_n;
    wire ab_pop   = ~bypass & b_rd_req & a_to_b_empty_n;
    wire ba_push  = ~bypass & b_wr_req & b_to_a_full_n;
    wire ba_pop   = ~bypass & a_rd & b_to_a_empty_n;
    wire ab_byp_wr = bypass & a_wr & ~ab_msg_valid;
    wire ab_byp_rd = bypass & b_rd_req & ab_msg_valid;
    wire ba_byp_wr = bypass & b_wr_req & ~ba_msg_valid;
    wire ba_byp_rd = bypass & a_rd & ba_msg_valid;

    wire [8:0] ab_next = next_count(ab_count, ab_push, ab_pop);
    wire [8:0] ba_next = next_count(ba_count, ba_push, ba_pop);
    wire       ab_msg_next = ab_byp_wr | (ab_msg_valid & ~ab_byp_rd);
    wire       ba_msg_next = ba_byp_wr | (ba_msg_valid & ~ba_byp_rd);

    // Mode and offsets, written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode      <= bsfpb_pkg::MODE_NORMAL;
            off_ae_ab <= bsfpb_pkg::OFFSET_RESET;
            off_af_ab <= bsfpb_pkg::OFFSET_RESET;
            off_ae_ba <= bsfpb_pkg::OFFSET_RESET;
            off_af_ba <= bsfpb_pkg::OFFSET_RESET;
        end else if (clear) begin
            mode      <= bsfpb_pkg::MODE_NORMAL;
            off_ae_ab <= bsfpb_pkg::OFFSET_RESET;
            off_af_ab <= bsfpb_pkg::OFFSET_RESET;
            off_ae_ba <= bsfpb_pkg::OFFSET_RESET;
            off_af_ba <= bsfpb_pkg::OFFSET_RESET;
        end else if (wr_go) begin
            if (sel_ctrl) begin
                mode <= pwdata[bsfpb_pkg::CTRL_BYPASS_BIT] ? bsfpb_pkg::MODE_BYPASS
                                                           : bsfpb_pkg::MODE_NORMAL;
            end
            if (sel_aeab) off_ae_ab <= pwdata[8:0];
            if (sel_afab) off_af_ab <= pwdata[8:0];
            if (sel_aeba) off_ae_ba <= pwdata[8:0];
            if (sel_afba) off_af_ba <= pwdata[8:0];
        end
    end

    // Bypass message registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ab_msg       <= '0;
            ba_msg       <= '0;
            ab_msg_valid <= 1'b0;
            ba_msg_valid <= 1'b0;
        end else begin
            ab_msg_valid <= ab_msg_next & ~clear;
            ba_msg_valid <= ba_msg_next & ~clear;
            if (ab_byp_wr) ab_msg <= pwdata[17:0];
            if (ba_byp_wr) ba_msg <= b_data;
        end
    end

    // ****************************************************************
    // Queues
    // ****************************************************************
    bsfpb_queue u_queue_ab (
        .clk       (pclk),
        .rst_n     (presetn),
        .clear     (clear),
        .push      (ab_push),
        .push_data (pwdata[17:0]),
        .pop       (ab_pop),
        .head      (ab_head),
        .count     (ab_count)
    );

    bsfpb_queue u_queue_ba (
        .clk       (pclk),
        .rst_n     (presetn),
        .clear     (clear),
        .push      (ba_push),
        .push_data (b_data),
        .pop       (ba_pop),
        .head      (ba_head),
        .count     (ba_count)
    );

    // ****************************************************************
    // Flags
    // ****************************************************************
    // Port A side flags update every cycle from the next occupancy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_to_b_full_n         <= 1'b1;
            a_to_b_almost_full_n  <= 1'b1;
            b_to_a_empty_n        <= 1'b0;
            b_to_a_almost_empty_n <= 1'b0;
        end else if (clear) begin
            a_to_b_full_n         <= 1'b1;
            a_to_b_almost_full_n  <= 1'b1;
            b_to_a_empty_n        <= 1'b0;
            b_to_a_almost_empty_n <= 1'b0;
        end else begin
            a_to_b_full_n <= bypass ? ~ab_msg_next
                                    : (ab_next != bsfpb_pkg::DEPTH_COUNT);
            a_to_b_almost_full_n  <= almost_full_n(ab_next, off_af_ab);
            b_to_a_empty_n        <= bypass ? ba_msg_next : (ba_next != 9'h000);
            b_to_a_almost_empty_n <= almost_empty_n(ba_next, off_ae_ba);
        end
    end

    // Port B side flags change only at a Port B clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_to_b_empty_n            <= 1'b0;
            a_to_b_almost_empty_n     <= 1'b0;
            b_to_a_full_n             <= 1'b1;
            b_to_a_almost_full_n      <= 1'b1;
            port_b_bypass_indicator_n <= 1'b1;
        end else if (clear) begin
            a_to_b_empty_n            <= 1'b0;
            a_to_b_almost_empty_n     <= 1'b0;
            b_to_a_full_n             <= 1'b1;
            b_to_a_almost_full_n      <= 1'b1;
            port_b_bypass_indicator_n <= 1'b1;
        end else if (b_edge) begin
            a_to_b_empty_n <= bypass ? ab_msg_next : (ab_next != 9'h000);
            a_to_b_almost_empty_n <= almost_empty_n(ab_next, off_ae_ab);
            b_to_a_full_n <= bypass ? ~ba_msg_next
                                    : (ba_next != bsfpb_pkg::DEPTH_COUNT);
            b_to_a_almost_full_n      <= almost_full_n(ba_next, off_af_ba);
            port_b_bypass_indicator_n <= ~bypass;
        end
    end

    // ****************************************************************
    // Port B data bus
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_data_out <= '0;
            port_b_data_oe  <= 1'b0;
        end else begin
            port_b_data_oe <= b_dir_rd & ~b_oe_n;
            if (ab_pop) begin
                port_b_data_out <= ab_head;
            end else if (ab_byp_rd) begin
                port_b_data_out <= ab_msg;
            end
        end
    end

    // ****************************************************************
    // APB read side: zero wait states, error on unmapped address
    // ****************************************************************
    wire [31:0] status_word = {23'h0, port_b_bypass_indicator_n, b_to_a_full_n,
                               b_to_a_almost_full_n, b_to_a_almost_empty_n, b_to_a_empty_n,
                               a_to_b_full_n, a_to_b_almost_full_n, a_to_b_almost_empty_n,
                               a_to_b_empty_n};
    wire [17:0] a_rd_word   = bypass ? ba_msg : ba_head;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = sel_ctrl ? {31'h0, bypass}
                   : sel_stat ? status_word
                   : sel_data ? {14'h0, a_rd_word}
                   : sel_aeab ? {23'h0, off_ae_ab}
                   : sel_afab ? {23'h0, off_af_ab}
                   : sel_aeba ? {23'h0, off_ae_ba}
                   : sel_afba ? {23'h0, off_af_ba}
                   : 32'h0000_0000;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_b_read_normal;
        b_rd_req && a_to_b_empty_n && !bypass;
    endsequence

    sequence s_b_read_bypass;
        bypass && b_rd_req && ab_msg_valid;
    endsequence

    AST_B_FLAGS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !b_edge && !clear |=> $stable(a_to_b_empty_n) && $stable(b_to_a_full_n))
        else $error("Port B flag changed without a Port B edge");

    AST_B_READ_DATA: assert property (@(posedge pclk) disable iff (!presetn || clear)
        s_b_read_normal |=> port_b_data_out == $past(ab_head) && ab_count == $past(ab_next))
        else $error("Port B read did not deliver the queue head");

    AST_EMPTY_NO_POP: assert property (@(posedge pclk) disable iff (!presetn || clear)
        b_rd_req && !a_to_b_empty_n && !bypass
        |=> ab_count == $past(ab_count) + 9'($past(ab_push)))
        else $error("Read popped an empty queue");

    AST_OE_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> port_b_data_oe == ($past(b_dir_rd) && !$past(b_oe_n)))
        else $error("Port B bus not driven in read with enable low");

    AST_AB_FULL: assert property (@(posedge pclk) disable iff (!presetn || clear)
        !bypass && ab_count == bsfpb_pkg::DEPTH_COUNT && !ab_pop ##1 !bypass
        |-> !a_to_b_full_n)
        else $error("Full flag high with a full queue");

    AST_BYPASS_IND: assert property (@(posedge pclk) disable iff (!presetn || clear)
        b_edge |=> port_b_bypass_indicator_n == !$past(bypass))
        else $error("Bypass indicator wrong after Port B edge");

    AST_BYP_AB_CLEAR: assert property (@(posedge pclk) disable iff (!presetn || clear)
        s_b_read_bypass |=> !a_to_b_empty_n && port_b_data_out == $past(ab_msg))
        else $error("A-to-B empty flag stayed high after bypass read");

    AST_BYP_BA_CLEAR: assert property (@(posedge pclk) disable iff (!presetn || clear)
        ba_byp_rd && !ba_byp_wr |=> !b_to_a_empty_n)
        else $error("B-to-A empty flag not low the cycle after Port A read");

    AST_BA_AEMPTY: assert property (@(posedge pclk) disable iff (!presetn || clear)
        ##1 1'b1 |-> b_to_a_almost_empty_n == ($past(ba_next) > $past(off_ae_ba)))
        else $error("B-to-A almost-empty flag disagrees with occupancy");

    AST_AB_AFULL: assert property (@(posedge pclk) disable iff (!presetn || clear)
        ##1 1'b1 |-> a_to_b_almost_full_n ==
                     (({1'b0, $past(ab_next)} + {1'b0, $past(off_af_ab)}) <= 10'h100))
        else $error("A-to-B almost-full flag disagrees with occupancy");

    AST_CLEAR_DEFAULTS: assert property (@(posedge pclk) disable iff (!presetn)
        clear |=> off_ae_ab == bsfpb_pkg::OFFSET_RESET && off_af_ba == bsfpb_pkg::OFFSET_RESET
                  && !a_to_b_empty_n && b_to_a_full_n && !bypass)
        else $error("Reset did not restore defaults");

endmodule

// *** bsfpb_pkg.sv ***
package bsfpb_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int         WIDTH       = 18;
    localparam int         CNT_W       = 9;
    localparam int         PTR_W       = 8;
    localparam int         DEPTH       = 256;
    localparam logic [8:0] DEPTH_COUNT = 9'h100;

    // ****************************************************************
    // Register map (byte addresses) and reset values
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_DATA   = 12'h008;
    localparam logic [11:0] ADDR_AE_AB  = 12'h00c;
    localparam logic [11:0] ADDR_AF_AB  = 12'h010;
    localparam logic [11:0] ADDR_AE_BA  = 12'h014;
    localparam logic [11:0] ADDR_AF_BA  = 12'h018;
    localparam logic [8:0]  OFFSET_RESET = 9'h008;
    localparam int          CTRL_BYPASS_BIT = 0;

    // Status bit positions
    localparam int ST_AB_EMPTY_N  = 0;
    localparam int ST_AB_AEMPTY_N = 1;
    localparam int ST_AB_AFULL_N  = 2;
    localparam int ST_AB_FULL_N   = 3;
    localparam int ST_BA_EMPTY_N  = 4;
    localparam int ST_BA_AEMPTY_N = 5;
    localparam int ST_BA_AFULL_N  = 6;
    localparam int ST_BA_FULL_N   = 7;
    localparam int ST_BYPASS_N    = 8;

    // Port B direction encoding
    localparam logic DIR_READ = 1'b1;

    // ****************************************************************
    // Operating mode
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b01,
        MODE_BYPASS = 2'b10
    } bsfpb_mode_t;

endpackage

// *** bsfpb_queue.sv ***
`timescale 1ns/1ps
module bsfpb_queue (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          clear,
    input  wire logic                          push,
    input  wire logic [bsfpb_pkg::WIDTH-1:0]   push_data,
    input  wire logic                          pop,
    output logic      [bsfpb_pkg::WIDTH-1:0]   head,
    output logic      [bsfpb_pkg::CNT_W-1:0]   count
);

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    logic [bsfpb_pkg::WIDTH-1:0] mem [bsfpb_pkg::DEPTH];
    logic [bsfpb_pkg::PTR_W-1:0] wr_ptr;
    logic [bsfpb_pkg::PTR_W-1:0] rd_ptr;

    // Oldest word is always visible at the head
    assign head = mem[rd_ptr];

    // Memory write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // Pointers and occupancy; caller guards push at full and pop at empty
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= wr_ptr + 8'(push);
            rd_ptr <= rd_ptr + 8'(pop);
            count  <= count + 9'(push) - 9'(pop);
        end
    end

endmodule

// *** bsfpb_portb_host.sv ***
`timescale 1ns/1ps
// Port B host: free running clock, one word every second clock rise
module bsfpb_portb_host (
    output logic             port_b_clock,
    output logic             en_n,
    output logic             dir,
    output logic             oe_n,
    output logic      [17:0] wdata,
    input  wire logic [17:0] rdata,
    input  wire logic        oe
);
    logic oe_seen;
    // Clock with a 125 ns period, controls idle; phase kept off the pclk edges
    initial begin
        port_b_clock = 1'b0;
        en_n = 1'b1;
        dir = 1'b1;
        oe_n = 1'b1;
        wdata = 18'h0_0000;
        oe_seen = 1'b0;
        #0.3;
        forever #62.5 port_b_clock = ~port_b_clock;
    end
    // Controls change at the falling edge, held across the rise
    task automatic xfer(input logic rd, input logic [17:0] d, output logic [17:0] q);
        @(negedge port_b_clock);
        en_n <= 1'b0;
        dir <= rd;
        oe_n <= ~rd;
        wdata <= rd ? ~wdata : d;
        @(negedge port_b_clock);
        q = oe ? rdata : ~rdata; // Undriven bus reads as the inverse
        oe_seen = oe;
        en_n <= 1'b1;
        oe_n <= 1'b1;
        wdata <= ~wdata; // Released bus shows the inverse
    endtask
endmodule

// *** bsfpb_flags_portb_tb.sv ***
`timescale 1ns/1ps
module bsfpb_flags_portb_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mrst_n, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, w;
    logic        bclk, en_n, dir, oe_n, oe;
    logic [17:0] bin, bout, rd, x;
    logic        ab_e, ab_ae, ab_af, ab_f, ba_e, ba_ae, ba_af, ba_f, byp_n;
    int          err_count, n_compared, seed;
    logic [17:0] q[$];

    bsfpb_flags_portb DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .master_reset_n(mrst_n), .port_b_clock(bclk),
        .port_b_transfer_enable_n(en_n), .port_b_direction(dir),
        .port_b_output_enable_n(oe_n), .port_b_data_in(bin), .port_b_data_out(bout),
        .port_b_data_oe(oe), .a_to_b_empty_n(ab_e), .a_to_b_almost_empty_n(ab_ae),
        .a_to_b_almost_full_n(ab_af), .a_to_b_full_n(ab_f), .b_to_a_empty_n(ba_e),
        .b_to_a_almost_empty_n(ba_ae), .b_to_a_almost_full_n(ba_af),
        .b_to_a_full_n(ba_f), .port_b_bypass_indicator_n(byp_n));
    bsfpb_portb_host host (.port_b_clock(bclk), .en_n(en_n), .dir(dir), .oe_n(oe_n),
        .wdata(bin), .rdata(bout), .oe(oe));

    // Expected {full_n, almost_full_n, almost_empty_n, empty_n} for n words, offsets 8
    function automatic logic [3:0] fl(input int n);
        return {n < 256, n + 8 <= 256, n > 8, n > 0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, data taken at the edge where pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic final_report;
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watchdog
    initial begin
        #200000;
        err_count++;
        final_report();
    end
    // Main sequence
    initial begin
        seed = 32'h1bc5;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        mrst_n = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, bsfpb_pkg::ADDR_STATUS, 32'h0000_0000);
        chk(v, {23'h0, 1'b1, fl(0), fl(0)});
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(bsfpb_pkg::ADDR_AE_AB + 4 * i), 32'h0000_0000);
            chk(v, 32'h0000_0008);
        end
        apb(1'b0, 12'h0ff, 32'h0000_0000);
        chk(e, 1'b1);
        // Fill A-to-B past full, one extra write dropped
        for (int n = 1; n <= 257; n++) begin
            w = $random(seed);
            apb(1'b1, bsfpb_pkg::ADDR_DATA, {14'h0, w[17:0]});
            if (n <= 256) q.push_back(w[17:0]);
            if (n inside {1, 8, 9, 248, 249, 256, 257}) begin
                repeat (70) @(posedge pclk);
                chk({ab_f, ab_af, ab_ae, ab_e}, fl(n > 256 ? 256 : n));
            end
        end
        // Drain through Port B, one read past empty
        for (int n = 0; n <= 256; n++) begin
            host.xfer(1'b1, 18'h0_0000, rd);
            if (q.size() > 0) x = q.pop_front();
            chk(rd, x);
            if (n == 0) chk(host.oe_seen, 1'b1);
        end
        repeat (70) @(posedge pclk);
        chk({ab_e, oe}, 2'b00);
        // Fill B-to-A from Port B past full, one extra write dropped
        for (int i = 0; i <= 256; i++) begin
            w = $random(seed);
            host.xfer(1'b0, w[17:0], rd);
            if (i < 256) q.push_back(w[17:0]);
        end
        repeat (70) @(posedge pclk);
        chk(ba_e, 1'b1);
        chk({ba_f, ba_af, ba_ae, ba_e}, fl(256));
        for (int i = 0; i < 256; i++) begin
            apb(1'b0, bsfpb_pkg::ADDR_DATA, 32'h0000_0000);
            chk(v[17:0], q.pop_front());
        end
        repeat (2) @(posedge pclk);
        chk(ba_e, 1'b0);
        // Bypass messages both ways
        apb(1'b1, bsfpb_pkg::ADDR_CTRL, 32'h0000_0001);
        w = $random(seed);
        apb(1'b1, bsfpb_pkg::ADDR_DATA, {14'h0, w[17:0]});
        repeat (70) @(posedge pclk);
        chk({byp_n, ab_f, ab_e}, 3'b001);
        host.xfer(1'b1, 18'h0_0000, rd);
        chk(rd, w[17:0]);
        w = $random(seed);
        host.xfer(1'b0, w[17:0], rd);
        repeat (70) @(posedge pclk);
        chk({ab_f, ab_e, ba_f, ba_e}, 4'b1001);
        apb(1'b0, bsfpb_pkg::ADDR_DATA, 32'h0000_0000);
        chk(v[17:0], w[17:0]);
        repeat (2) @(posedge pclk);
        chk(ba_e, 1'b0);
        repeat (70) @(posedge pclk);
        chk(ba_f, 1'b1);
        // Device reset clears mode, flags and offsets
        apb(1'b1, bsfpb_pkg::ADDR_AE_BA, 32'h0000_0005);
        mrst_n <= 1'b0;
        repeat (10) @(posedge pclk);
        mrst_n <= 1'b1;
        repeat (70) @(posedge pclk);
        apb(1'b0, bsfpb_pkg::ADDR_STATUS, 32'h0000_0000);
        chk(v, {23'h0, 1'b1, fl(0), fl(0)});
        apb(1'b0, bsfpb_pkg::ADDR_AE_BA, 32'h0000_0000);
        chk(v, 32'h0000_0008);
        final_report();
    end
endmodule
